// File: pit_pkg.sv
// pit_pkg: register map, field layout and reset values of the prescaled interval timer
// assumes: a 32-bit AXI4-Lite register bus, one word per register
package pit_pkg;

  localparam int          ADDR_W         = 5;
  // register byte offsets
  localparam logic [4:0]  OFF_COUNT      = 5'h00;
  localparam logic [4:0]  OFF_PRESCALE   = 5'h04;
  localparam logic [4:0]  OFF_PERIOD     = 5'h08;
  localparam logic [4:0]  OFF_STATUS     = 5'h0C;
  localparam logic [4:0]  OFF_MASK       = 5'h10;
  // field widths and positions
  localparam int          COUNT_W        = 16;
  localparam int          SCALE_W        = 8;
  localparam int          EXPIRE_BIT     = 0;
  // reset values
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  localparam logic [7:0]  PRESCALE_RST   = 8'h00;
  localparam logic [15:0] PERIOD_RST     = 16'h0000;
  localparam logic        STATUS_RST     = 1'b0;
  localparam logic        MASK_RST       = 1'b0;
  // bus answers
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // software-visible timer settings
  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  prescale;
    logic [15:0] period;
  } pit_regs_t;

endpackage

// File: pit_timer.sv
// pit_timer: prescaled 16-bit interval timer with an AXI4-Lite register slave
// assumes: timer_en comes from core logic on aclk; irq is read by the same clock domain
// Operation
// [RULE1] An 8-bit prescale value n-1 gives one count step every n clock cycles.
// [RULE2] The 16-bit count value drops by one on each prescale step.
// [RULE3] A timer interrupt toward the core is raised when the count reaches zero.
// [RULE4] On reaching zero the count is reloaded from the 16-bit period value.
// [RULE5] Prescaler and counter advance only while the core's timer enable is high.
`timescale 1ns/1ps
`default_nettype none

module pit_timer (
  input  wire logic        aclk,           // clock, 100 MHz
  input  wire logic        aresetn,        // synchronous reset, active low
  input  wire logic        timer_en,       // core enable for counting
  input  wire logic [4:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [4:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic             tick_irq,       // one-cycle pulse on expiry
  output logic             irq             // level, unmasked sticky status
);

  pit_pkg::pit_regs_t regs_q;
  logic [7:0]         pre_q;
  logic               status_q;
  logic               mask_q;
  logic               tick_q;
  logic               irq_q;

  logic               awready_q;
  logic               wready_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic [4:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               arready_q;
  logic               rvalid_q;
  logic [1:0]         rresp_q;
  logic [31:0]        rdata_q;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // write channel bookkeeping
  logic aw_have;
  logic w_have;
  logic wr_do;
  logic wr_count;
  logic wr_scale;
  logic wr_period;
  logic wr_mask;
  logic addr_ok_w;
  logic [31:0] wmerge;

  assign aw_have   = !awready_q;
  assign w_have    = !wready_q;
  assign wr_do     = aw_have && w_have && !bvalid_q;
  assign addr_ok_w = (awaddr_q == pit_pkg::OFF_COUNT) || (awaddr_q == pit_pkg::OFF_PRESCALE)
                  || (awaddr_q == pit_pkg::OFF_PERIOD) || (awaddr_q == pit_pkg::OFF_STATUS)
                  || (awaddr_q == pit_pkg::OFF_MASK);
  assign wr_count  = wr_do && (awaddr_q == pit_pkg::OFF_COUNT);
  assign wr_scale  = wr_do && (awaddr_q == pit_pkg::OFF_PRESCALE);
  assign wr_period = wr_do && (awaddr_q == pit_pkg::OFF_PERIOD);
  assign wr_mask   = wr_do && (awaddr_q == pit_pkg::OFF_MASK);

  always_comb begin
    wmerge = 32'h0000_0000;
    unique case (1'b1)
      wr_count:  wmerge = merge_bytes({16'h0000, regs_q.count}, wdata_q, wstrb_q);
      wr_scale:  wmerge = merge_bytes({24'h00_0000, regs_q.prescale}, wdata_q, wstrb_q);
      wr_period: wmerge = merge_bytes({16'h0000, regs_q.period}, wdata_q, wstrb_q);
      wr_mask:   wmerge = merge_bytes({31'h0000_0000, mask_q}, wdata_q, wstrb_q);
      default:   wmerge = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      awaddr_q  <= 5'h00;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pit_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_ok_w ? pit_pkg::RESP_OKAY : pit_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // prescaler and counter
  logic step;
  logic expire;

  assign step   = timer_en && (pre_q == 8'h00); // RULE1 RULE5
  assign expire = step && (regs_q.count <= 16'h0001); // RULE3

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= pit_pkg::PRESCALE_RST;
    end else if (wr_scale) begin
      pre_q <= wmerge[7:0];
    end else if (step) begin
      pre_q <= regs_q.prescale; // RULE1
    end else if (timer_en) begin
      pre_q <= pre_q - 8'h01; // RULE1 RULE5
    end
  end

  // all fields of the settings struct share one process, so it has a single driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_q.count    <= pit_pkg::COUNT_RST;
      regs_q.prescale <= pit_pkg::PRESCALE_RST;
      regs_q.period   <= pit_pkg::PERIOD_RST;
      mask_q          <= pit_pkg::MASK_RST;
    end else begin
      if (wr_count) begin
        regs_q.count <= wmerge[15:0];
      end else if (expire) begin
        regs_q.count <= regs_q.period; // RULE4
      end else if (step) begin
        regs_q.count <= regs_q.count - 16'h0001; // RULE2
      end
      if (wr_scale) begin
        regs_q.prescale <= wmerge[7:0];
      end
      if (wr_period) begin
        regs_q.period <= wmerge[15:0];
      end
      if (wr_mask) begin
        mask_q <= wmerge[pit_pkg::EXPIRE_BIT];
      end
    end
  end

  // read channel
  logic rd_take;
  logic rd_status;

  assign rd_take   = arready_q && s_axi_arvalid;
  assign rd_status = rd_take && (s_axi_araddr == pit_pkg::OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= pit_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= pit_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        pit_pkg::OFF_COUNT:    rdata_q <= {16'h0000, regs_q.count};
        pit_pkg::OFF_PRESCALE: rdata_q <= {24'h00_0000, regs_q.prescale};
        pit_pkg::OFF_PERIOD:   rdata_q <= {16'h0000, regs_q.period};
        pit_pkg::OFF_STATUS:   rdata_q <= {31'h0000_0000, status_q};
        pit_pkg::OFF_MASK:     rdata_q <= {31'h0000_0000, mask_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= pit_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // sticky expiry flag; a new expiry wins over the clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= pit_pkg::STATUS_RST;
    end else if (expire) begin
      status_q <= 1'b1; // RULE3
    end else if (rd_status) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      tick_q <= expire; // RULE3
      irq_q  <= (status_q || expire) && mask_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign tick_irq      = tick_q;
  assign irq           = irq_q;

  prescale_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    step && !wr_scale |=> pre_q == $past(regs_q.prescale))
    else $error("prescaler not reloaded on step");

  prescale_run_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    timer_en && pre_q > 8'h00 && !wr_scale |=> pre_q == $past(pre_q) - 8'h01)
    else $error("prescaler did not count down");

  count_dec_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    step && regs_q.count > 16'h0001 && !wr_count
    |=> regs_q.count == $past(regs_q.count) - 16'h0001)
    else $error("count did not decrement on step");

  count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    !step && !wr_count |=> $stable(regs_q.count))
    else $error("count moved without a step");

  expire_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    step && regs_q.count <= 16'h0001 |=> tick_irq && status_q)
    else $error("no interrupt when count reached zero");

  count_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    expire && !wr_count && !wr_period |=> regs_q.count == $past(regs_q.period))
    else $error("count not reloaded from period");

  enable_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    !timer_en && !wr_scale && !wr_count |=> $stable(pre_q) && $stable(regs_q.count))
    else $error("timer advanced while disabled");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_q && mask_q |=> irq)
    else $error("unmasked status did not raise irq");

  irq_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !status_q && !expire |=> !irq)
    else $error("irq high without status");

  status_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    status_q && !rd_status |=> status_q)
    else $error("status cleared without a read");

  status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    rd_status && !expire |=> !status_q)
    else $error("status read did not clear");

  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

endmodule // pit_timer

`default_nettype wire

// File: pit_timer_tb.sv
// pit_timer_tb: self-checking bench for the prescaled interval timer
// assumes: pit_pkg and pit_timer are compiled first; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module pit_timer_tb;
  logic        aclk, aresetn, timer_en;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, tick_irq, irq;
  int          n_fail, cmp_count, gap;

  pit_timer dut (
    .aclk(aclk), .aresetn(aresetn), .timer_en(timer_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tick_irq(tick_irq), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a wait that ran out of its bound
  task automatic hang;
    n_fail++;
    print_verdict();
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (aw_ok && w_ok && bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (rvalid) begin
        d = rdata;
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
      if (arvalid && arready) arvalid <= 1'b0;
    end
    hang();
  endtask

  // counts edges up to and including the next tick pulse
  task automatic wait_tick(output int n);
    n = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge aclk);
      n++;
      if (tick_irq === 1'b1) return;
    end
    hang();
  endtask

  // reset values, unmapped place, register widths, frozen counter
  task automatic reg_scn;
    for (int k = 0; k < 5; k++) begin
      rd(5'(4 * k), pit_pkg::RESP_OKAY, v);
      chk(v, 32'h0000_0000);
    end
    rd(5'h14, pit_pkg::RESP_SLVERR, v);
    chk(v, 32'h0000_0000);
    wr(5'h14, 32'h0000_0001, pit_pkg::RESP_SLVERR);
    wr(pit_pkg::OFF_PERIOD, 32'hABCD_1234, pit_pkg::RESP_OKAY);
    rd(pit_pkg::OFF_PERIOD, pit_pkg::RESP_OKAY, v);
    chk(v, 32'h0000_1234);
    wstrb <= 4'h2;
    wr(pit_pkg::OFF_PERIOD, 32'h0000_5600, pit_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(pit_pkg::OFF_PERIOD, pit_pkg::RESP_OKAY, v);
    chk(v, 32'h0000_5634);
    wr(pit_pkg::OFF_COUNT, 32'hFFFF_0003, pit_pkg::RESP_OKAY);
    repeat (8) @(posedge aclk);
    rd(pit_pkg::OFF_COUNT, pit_pkg::RESP_OKAY, v);
    chk(v, 32'h0000_0003);
  endtask

  // expiry spacing, reload, sticky status and masked level interrupt
  task automatic interval_scn(input int s, input int p, input int m);
    timer_en <= 1'b0;
    wr(pit_pkg::OFF_MASK, 32'(m), pit_pkg::RESP_OKAY);
    wr(pit_pkg::OFF_PRESCALE, 32'(s), pit_pkg::RESP_OKAY);
    wr(pit_pkg::OFF_PERIOD, 32'(p), pit_pkg::RESP_OKAY);
    timer_en <= 1'b1;
    wait_tick(gap);
    wait_tick(gap);
    chk(32'(gap), 32'((s + 1) * p));
    chk(32'(irq), 32'(m));
    timer_en <= 1'b0;
    rd(pit_pkg::OFF_STATUS, pit_pkg::RESP_OKAY, v);
    chk(v, 32'h0000_0001);
    rd(pit_pkg::OFF_STATUS, pit_pkg::RESP_OKAY, v);
    chk(v, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    rd(pit_pkg::OFF_COUNT, pit_pkg::RESP_OKAY, v);
    chk(32'(v != 0 && v <= 32'(p)), 32'h0000_0001);
  endtask

  initial begin
    aresetn = 1'b0;
    timer_en = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_scn();
    interval_scn(0, 5, 1);
    interval_scn(2, 5, 0);
    interval_scn(1, 1, 1);
    interval_scn(255, 2, 1);
    print_verdict();
  end
endmodule // pit_timer_tb
`default_nettype wire
